// ### common/cfm_defs.svh
`ifndef CFM_DEFS_SVH
`define CFM_DEFS_SVH

// ************************************************************
// Register offsets (byte addresses, one 32-bit word each)
// ************************************************************
`define CFM_OFS_CHAN_CTRL 8'h00
`define CFM_OFS_MIER_UPPER 8'h04
`define CFM_OFS_TXQ_CTRL 8'h08
`define CFM_OFS_RXQ_CTRL 8'h0c
`define CFM_OFS_TXQ_PTR 8'h10
`define CFM_OFS_RXQ_PTR 8'h14
`define CFM_OFS_MASK_A 8'h18
`define CFM_OFS_MASK_B 8'h1c
`define CFM_OFS_IDCMP_A 8'h20
`define CFM_OFS_IDCMP_B 8'h24
`define CFM_OFS_MSG_CTRL 8'h28
`define CFM_OFS_TX_ID 8'h30
`define CFM_OFS_TX_DLC 8'h34
`define CFM_OFS_TX_DLO 8'h38
`define CFM_OFS_TX_DHI 8'h3c
`define CFM_OFS_RX_ID 8'h40
`define CFM_OFS_RX_DLC 8'h44
`define CFM_OFS_RX_DLO 8'h48
`define CFM_OFS_RX_DHI 8'h4c

// ************************************************************
// Field positions
// ************************************************************
`define CFM_BIT_MODE_SEL 0
`define CFM_BIT_LOST_SEL 1
`define CFM_BIT_TXQ_IE 24
`define CFM_BIT_TXQ_ITIM 25
`define CFM_BIT_RXQ_IE 28
`define CFM_BIT_RXQ_ITIM 29
`define CFM_BIT_TXQ_EN 0
`define CFM_BIT_TXQ_FULL 1
`define CFM_BIT_TXQ_EMPTY 2
`define CFM_BIT_RXQ_EN 0
`define CFM_BIT_RXQ_LOST 1
`define CFM_BIT_RXQ_FULL 2
`define CFM_BIT_RXQ_WARN 3
`define CFM_BIT_RXQ_EMPTY 4
`define CFM_BIT_ID_RTR 30
`define CFM_BIT_ID_IDE 31

// ************************************************************
// Values and counts
// ************************************************************
`define CFM_PTR_ADVANCE 8'hff
`define CFM_QUEUE_DEPTH 3'h4
`define CFM_QUEUE_WARN 3'h3
`define CFM_RST_WORD 32'h0000_0000
`define CFM_RST_BYTE 8'h00

`endif

// ### common/cfm_pkg.sv
package cfm_pkg;

    // One queued CAN message
    typedef struct packed {
        logic ide;
        logic rtr;
        logic [28:0] id;
        logic [3:0] dlc;
        logic [63:0] data;
    } cfm_msg_s;

    // Outcome strobes from the protocol engine for a queued frame
    typedef struct packed {
        logic done;
        logic error;
        logic arb_lost;
        logic halt;
    } cfm_txev_s;

    typedef logic [2:0] cfm_count_t;

endpackage

// ### rtl/cfm_queue.sv
`timescale 1ns/1ps
`include "cfm_defs.svh"

module cfm_queue (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic push,
    input wire cfm_pkg::cfm_msg_s push_msg,
    input wire logic pop,
    input wire logic flush,
    // State
    output cfm_pkg::cfm_count_t count,
    output cfm_pkg::cfm_msg_s head
);

    // ************************************************************
    // Four-stage message store
    // ************************************************************
    cfm_pkg::cfm_msg_s mem_ff [0:3];
    logic [1:0] rd_ptr_ff;
    logic [1:0] wr_ptr_ff;
    cfm_pkg::cfm_count_t count_ff;
    logic do_push;
    logic do_pop;

    // Push at full is only legal together with a pop (overwrite)
    assign do_pop = pop && (count_ff != 3'h0);
    assign do_push = push && ((count_ff != `CFM_QUEUE_DEPTH) || do_pop);

    // Message storage, no reset needed for data
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_ff[wr_ptr_ff] <= push_msg;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            rd_ptr_ff <= 2'h0;
            wr_ptr_ff <= 2'h0;
            count_ff <= 3'h0;
        end else begin
            if (do_push) begin
                wr_ptr_ff <= wr_ptr_ff + 2'h1;
            end
            if (do_pop) begin
                rd_ptr_ff <= rd_ptr_ff + 2'h1;
            end
            if (do_push && !do_pop) begin
                count_ff <= count_ff + 3'h1;
            end else if (do_pop && !do_push) begin
                count_ff <= count_ff - 3'h1;
            end
        end
    end

    assign count = count_ff;
    assign head = mem_ff[rd_ptr_ff];

endmodule

// ### rtl/cfm_top.sv
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "cfm_defs.svh"

// Functional notes
// [RULE1] FIFO mode: 56-59 transmit, 60-63 receive queue
// [RULE2] Software writes slot 56, reads slot 60
// [RULE3] Pointers advance only on all-ones byte write
// [RULE4] Bit 24 gates transmit queue interrupt
// [RULE5] Bit 25: every send or only when emptied; code fires on the pop at level one even if a push refills the queue
// [RULE6] Bit 28 gates receive queue interrupt
// [RULE7] Bit 29: every receive or at warning level
// [RULE8] No interrupt when dropping full to warning
// [RULE9] Per-mailbox control of 56-63 ignored in FIFO mode
// [RULE10] Transmit enable runs queue; clearing halts it
// [RULE11] Disable mid-send flushes at next frame outcome
// [RULE12] Transmit queue four deep, empty and full flags
// [RULE13] Receive enable runs queue; clearing halts it
// [RULE14] Receive flags: empty 0, warning 3, full 4
// [RULE15] Frame at full receive queue sets lost flag
// [RULE16] Overrun: drop new frame, keep stored ones
// [RULE17] Overwrite: replace oldest, pointers auto advance
// [RULE18] Accept only on compare match under mask
// [RULE19] Software configures only in config or operation
// [RULE20] Abort by clearing enable; empty flag marks completion
// [RULE21] Software discards message overwritten during read
// [RULE22] Overrun never alters the presented read message
// [RULE23] Mode select: 0 normal, 1 FIFO mailbox
// [RULE24] Lost select: 0 overwrite, 1 overrun
// [RULE25] Other pointer control values change nothing

module cfm_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Protocol engine, transmit side
    output logic tx_frame_valid,
    output cfm_pkg::cfm_msg_s tx_frame,
    input wire logic tx_busy,
    input wire cfm_pkg::cfm_txev_s tx_event,
    // Protocol engine, receive side
    input wire logic rx_frame_valid,
    input wire cfm_pkg::cfm_msg_s rx_frame,
    // Interrupt requests
    output logic tx_queue_irq,
    output logic rx_queue_irq
);

    // ************
    // Helper functions
    // ************

    // Identifier word as seen by filter and register reads
    function automatic logic [31:0] id_word(input cfm_pkg::cfm_msg_s m);
        id_word = {m.ide, m.rtr, 1'b0, m.id};
    endfunction

    // Compare under mask: a mask bit of 1 makes the bit significant
    function automatic logic id_hit(input logic [31:0] idw, input logic [31:0] cmp, input logic [31:0] msk);
        id_hit = (((idw ^ cmp) & msk) == 32'h0000_0000);
    endfunction

    // ************
    // Register state
    // ************
    logic mode_fifo_ff, lost_overrun_ff, txq_en_ff, rxq_en_ff, rxq_lost_ff, tx_irq_ff, rx_irq_ff;
    logic [31:0] mier_ff, mask_a_ff, mask_b_ff, idcmp_a_ff, idcmp_b_ff, rdata_ff;
    logic [7:0] msg_ctrl_ff;
    cfm_pkg::cfm_msg_s tx_stage_ff;

    // Decoded strobes
    logic wr_chan, wr_mier, wr_txq, wr_rxq, tx_ptr_go, rx_ptr_go, frame_end;

    // Queue wiring
    cfm_pkg::cfm_count_t txq_count, rxq_count;
    cfm_pkg::cfm_msg_s txq_head, rxq_head;
    logic txq_push, txq_pop, txq_flush, rxq_push, rxq_pop, txq_active, rxq_active, rx_match, rx_take;
    logic txq_empty, txq_full, rxq_empty, rxq_warn, rxq_full;

    // Write strobes per register
    assign wr_chan = reg_wr && (reg_addr == `CFM_OFS_CHAN_CTRL);
    assign wr_mier = reg_wr && (reg_addr == `CFM_OFS_MIER_UPPER);
    assign wr_txq = reg_wr && (reg_addr == `CFM_OFS_TXQ_CTRL);
    assign wr_rxq = reg_wr && (reg_addr == `CFM_OFS_RXQ_CTRL);

    // Only the all-ones byte moves a pointer, anything else is dropped
    assign tx_ptr_go = reg_wr && (reg_addr == `CFM_OFS_TXQ_PTR) && (reg_wdata[7:0] == `CFM_PTR_ADVANCE); // [RULE3] [RULE25]
    assign rx_ptr_go = reg_wr && (reg_addr == `CFM_OFS_RXQ_PTR) && (reg_wdata[7:0] == `CFM_PTR_ADVANCE); // [RULE3] [RULE25]

    // Any outcome of the frame on the bus ends a pending abort
    assign frame_end = tx_event.done || tx_event.error || tx_event.arb_lost || tx_event.halt; // [RULE11]

    // ************
    // Channel control and interrupt enables
    // ************

    // Mode and lost handling select
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_fifo_ff <= 1'b0;
            lost_overrun_ff <= 1'b0;
        end else if (wr_chan) begin
            mode_fifo_ff <= reg_wdata[`CFM_BIT_MODE_SEL]; // [RULE23]
            lost_overrun_ff <= reg_wdata[`CFM_BIT_LOST_SEL]; // [RULE24]
        end
    end

    // Upper mailbox interrupt enable word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mier_ff <= `CFM_RST_WORD;
        end else if (wr_mier) begin
            mier_ff <= reg_wdata;
        end
    end

    // Queues exist only in FIFO mailbox mode
    assign txq_active = mode_fifo_ff && txq_en_ff; // [RULE1] [RULE10]
    assign rxq_active = mode_fifo_ff && rxq_en_ff; // [RULE1] [RULE13]

    // ************
    // Filter registers
    // ************

    // Two masks and two compare words, written freely
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mask_a_ff <= `CFM_RST_WORD;
            mask_b_ff <= `CFM_RST_WORD;
            idcmp_a_ff <= `CFM_RST_WORD;
            idcmp_b_ff <= `CFM_RST_WORD;
        end else if (reg_wr) begin
            if (reg_addr == `CFM_OFS_MASK_A) begin
                mask_a_ff <= reg_wdata;
            end else if (reg_addr == `CFM_OFS_MASK_B) begin
                mask_b_ff <= reg_wdata;
            end else if (reg_addr == `CFM_OFS_IDCMP_A) begin
                idcmp_a_ff <= reg_wdata;
            end else if (reg_addr == `CFM_OFS_IDCMP_B) begin
                idcmp_b_ff <= reg_wdata;
            end
        end
    end

    // Either compare word under either mask admits the frame
    assign rx_match = id_hit(id_word(rx_frame), idcmp_a_ff, mask_a_ff) ||
                      id_hit(id_word(rx_frame), idcmp_a_ff, mask_b_ff) ||
                      id_hit(id_word(rx_frame), idcmp_b_ff, mask_a_ff) ||
                      id_hit(id_word(rx_frame), idcmp_b_ff, mask_b_ff); // [RULE18]

    // ************
    // Per-mailbox control for the queue slots
    // ************

    // Kept for normal mode only; FIFO mode locks it so it steers nothing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            msg_ctrl_ff <= `CFM_RST_BYTE;
        end else if (reg_wr && (reg_addr == `CFM_OFS_MSG_CTRL) && !mode_fifo_ff) begin
            msg_ctrl_ff <= reg_wdata[7:0]; // [RULE9]
        end
    end

    // ************
    // Transmit queue
    // ************

    // Slot 56 staging: software composes the message here
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_stage_ff <= '0;
        end else if (reg_wr) begin
            if (reg_addr == `CFM_OFS_TX_ID) begin
                tx_stage_ff.ide <= reg_wdata[`CFM_BIT_ID_IDE]; // [RULE2]
                tx_stage_ff.rtr <= reg_wdata[`CFM_BIT_ID_RTR];
                tx_stage_ff.id <= reg_wdata[28:0];
            end else if (reg_addr == `CFM_OFS_TX_DLC) begin
                tx_stage_ff.dlc <= reg_wdata[3:0];
            end else if (reg_addr == `CFM_OFS_TX_DLO) begin
                tx_stage_ff.data[31:0] <= reg_wdata;
            end else if (reg_addr == `CFM_OFS_TX_DHI) begin
                tx_stage_ff.data[63:32] <= reg_wdata;
            end
        end
    end

    // Enable bit; a write of zero is the abort request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txq_en_ff <= 1'b0;
        end else if (wr_txq) begin
            txq_en_ff <= reg_wdata[`CFM_BIT_TXQ_EN]; // [RULE10] [RULE20]
        end
    end

    // Flush when idle and disabled, or at the outcome of the last frame
    assign txq_flush = !txq_en_ff && !txq_empty && (!tx_busy || frame_end); // [RULE11] [RULE20]
    assign txq_push = tx_ptr_go && txq_active && !txq_full; // [RULE3] [RULE12]
    assign txq_pop = tx_event.done && txq_active && !txq_empty;

    cfm_queue u_txq (
        .clk(clk),
        .rst_n(rst_n),
        .push(txq_push),
        .push_msg(tx_stage_ff),
        .pop(txq_pop),
        .flush(txq_flush),
        .count(txq_count),
        .head(txq_head)
    );

    // Transmit flags follow the fill level
    assign txq_empty = (txq_count == 3'h0); // [RULE12] [RULE20]
    assign txq_full = (txq_count == `CFM_QUEUE_DEPTH); // [RULE12]

    // Halted queue offers nothing to the engine
    assign tx_frame_valid = txq_active && !txq_empty; // [RULE10]
    assign tx_frame = txq_head;

    // ************
    // Receive queue
    // ************

    // Enable bit; halting keeps the stored messages
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxq_en_ff <= 1'b0;
        end else if (wr_rxq) begin
            rxq_en_ff <= reg_wdata[`CFM_BIT_RXQ_EN]; // [RULE13]
        end
    end

    // Accepted frame; at full the lost handling decides
    assign rx_take = rx_frame_valid && rxq_active && rx_match; // [RULE18]
    assign rxq_push = rx_take && (!rxq_full || !lost_overrun_ff || rx_ptr_go); // [RULE16] [RULE17]
    assign rxq_pop = (rx_ptr_go && rxq_active) || (rx_take && rxq_full && !lost_overrun_ff); // [RULE3] [RULE17]

    // Lost flag: set wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxq_lost_ff <= 1'b0;
        end else if (rx_take && rxq_full && !rx_ptr_go) begin
            rxq_lost_ff <= 1'b1; // [RULE15]
        end else if (wr_rxq && !reg_wdata[`CFM_BIT_RXQ_LOST]) begin
            rxq_lost_ff <= 1'b0;
        end
    end

    cfm_queue u_rxq (
        .clk(clk),
        .rst_n(rst_n),
        .push(rxq_push),
        .push_msg(rx_frame),
        .pop(rxq_pop),
        .flush(1'b0),
        .count(rxq_count),
        .head(rxq_head)
    );

    // Receive flags follow the fill level
    assign rxq_empty = (rxq_count == 3'h0); // [RULE14]
    assign rxq_warn = (rxq_count == `CFM_QUEUE_WARN); // [RULE14]
    assign rxq_full = (rxq_count == `CFM_QUEUE_DEPTH); // [RULE14]

    // ************
    // Interrupt requests
    // ************

    // Transmit: every completion, or only the pop at a fill level of one, even with a push in that cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_irq_ff <= 1'b0;
        end else begin
            tx_irq_ff <= txq_pop && mier_ff[`CFM_BIT_TXQ_IE] &&
                         (!mier_ff[`CFM_BIT_TXQ_ITIM] || (txq_count == 3'h1)); // [RULE4] [RULE5]
        end
    end

    // Receive: every store, or a store taking the level from two to three
    // A pop from full to three is no store, so it never fires
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_irq_ff <= 1'b0;
        end else begin
            rx_irq_ff <= rxq_push && mier_ff[`CFM_BIT_RXQ_IE] &&
                         (!mier_ff[`CFM_BIT_RXQ_ITIM] ||
                          (!rxq_pop && (rxq_count == (`CFM_QUEUE_WARN - 3'h1)))); // [RULE6] [RULE7] [RULE8]
        end
    end

    assign tx_queue_irq = tx_irq_ff;
    assign rx_queue_irq = rx_irq_ff;

    // ************
    // Read path
    // ************

    // Registered read data; slot 60 always shows the oldest message
    // In overrun mode the head only moves on a pointer write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_ff <= `CFM_RST_WORD;
        end else if (reg_rd) begin
            if (reg_addr == `CFM_OFS_CHAN_CTRL) begin
                rdata_ff <= {30'h0, lost_overrun_ff, mode_fifo_ff};
            end else if (reg_addr == `CFM_OFS_MIER_UPPER) begin
                rdata_ff <= mier_ff;
            end else if (reg_addr == `CFM_OFS_TXQ_CTRL) begin
                rdata_ff <= {29'h0, txq_empty, txq_full, txq_en_ff}; // [RULE12]
            end else if (reg_addr == `CFM_OFS_RXQ_CTRL) begin
                rdata_ff <= {27'h0, rxq_empty, rxq_warn, rxq_full, rxq_lost_ff, rxq_en_ff}; // [RULE14]
            end else if (reg_addr == `CFM_OFS_MASK_A) begin
                rdata_ff <= mask_a_ff;
            end else if (reg_addr == `CFM_OFS_MASK_B) begin
                rdata_ff <= mask_b_ff;
            end else if (reg_addr == `CFM_OFS_IDCMP_A) begin
                rdata_ff <= idcmp_a_ff;
            end else if (reg_addr == `CFM_OFS_IDCMP_B) begin
                rdata_ff <= idcmp_b_ff;
            end else if (reg_addr == `CFM_OFS_MSG_CTRL) begin
                rdata_ff <= {24'h0, msg_ctrl_ff};
            end else if (reg_addr == `CFM_OFS_TX_ID) begin
                rdata_ff <= id_word(tx_stage_ff);
            end else if (reg_addr == `CFM_OFS_TX_DLC) begin
                rdata_ff <= {28'h0, tx_stage_ff.dlc};
            end else if (reg_addr == `CFM_OFS_TX_DLO) begin
                rdata_ff <= tx_stage_ff.data[31:0];
            end else if (reg_addr == `CFM_OFS_TX_DHI) begin
                rdata_ff <= tx_stage_ff.data[63:32];
            end else if (reg_addr == `CFM_OFS_RX_ID) begin
                rdata_ff <= id_word(rxq_head); // [RULE2] [RULE22]
            end else if (reg_addr == `CFM_OFS_RX_DLC) begin
                rdata_ff <= {28'h0, rxq_head.dlc};
            end else if (reg_addr == `CFM_OFS_RX_DLO) begin
                rdata_ff <= rxq_head.data[31:0];
            end else if (reg_addr == `CFM_OFS_RX_DHI) begin
                rdata_ff <= rxq_head.data[63:32];
            end else begin
                rdata_ff <= `CFM_RST_WORD;
            end
        end else begin
            rdata_ff <= `CFM_RST_WORD;
        end
    end

    assign reg_rdata = rdata_ff;

endmodule

// ### testbench/cfm_engine_model.sv
`timescale 1ns/1ps

// ********
// Protocol engine stand-in
// ********
module cfm_engine_model (
    // Clock and pacing
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] lag,
    // Transmit side
    input wire logic tx_frame_valid,
    output logic tx_busy,
    output cfm_pkg::cfm_txev_s tx_event,
    // Receive side
    output logic rx_frame_valid,
    output cfm_pkg::cfm_msg_s rx_frame
);
    int cnt;

    // Quiet lines at time zero
    initial begin
        tx_busy = 1'b0;
        tx_event = '0;
        rx_frame_valid = 1'b0;
        rx_frame = '0;
        cnt = 0;
    end

    // Sends the head for lag+1 cycles, then pulses done; no restart in the done
    // cycle, since the queue has not yet popped and the head would be sent twice
    always @(posedge clk) begin
        tx_event <= '0;
        if (tx_busy) begin
            cnt <= cnt + 1;
            if (cnt >= lag) begin
                tx_busy <= 1'b0;
                tx_event.done <= 1'b1;
            end
        end else if (go && tx_frame_valid && !tx_event.done) begin
            tx_busy <= 1'b1;
            cnt <= 0;
        end
    end

    // One received frame; the released bus shows the inverse, not stale data
    task automatic rx_send(input logic [28:0] id);
        @(posedge clk);
        rx_frame_valid <= 1'b1;
        rx_frame <= {2'b00, id, 4'h8, 32'h0, 3'h0, id};
        @(posedge clk);
        rx_frame_valid <= 1'b0;
        rx_frame <= ~rx_frame;
    endtask
endmodule

// ### testbench/cfm_monitor.sv
`timescale 1ns/1ps
`include "cfm_defs.svh"

module cfm_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Engine side
    input wire logic tx_frame_valid,
    input wire cfm_pkg::cfm_msg_s tx_frame,
    input wire cfm_pkg::cfm_txev_s tx_event,
    input wire logic rx_frame_valid,
    // Interrupts
    input wire logic tx_queue_irq,
    input wire logic rx_queue_irq
);
    logic [1:0] chan_ff;
    logic [31:0] mier_ff;
    logic txen_ff;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Shadow of the control bits, rebuilt from bus writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chan_ff <= 2'h0;
            mier_ff <= 32'h0;
            txen_ff <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `CFM_OFS_CHAN_CTRL) chan_ff <= reg_wdata[1:0];
            if (reg_addr == `CFM_OFS_MIER_UPPER) mier_ff <= reg_wdata & 32'h3300_0000;
            if (reg_addr == `CFM_OFS_TXQ_CTRL) txen_ff <= reg_wdata[0];
        end
    end

    // ********
    // Checks
    // ********
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    chan_back_a: assert property ($past(reg_rd) && $past(reg_addr) == `CFM_OFS_CHAN_CTRL
        |-> reg_rdata[1:0] == $past(chan_ff)) else $error("channel control readback");
    mier_back_a: assert property ($past(reg_rd) && $past(reg_addr) == `CFM_OFS_MIER_UPPER
        |-> (reg_rdata & 32'h3300_0000) == $past(mier_ff)) else $error("interrupt enable readback");
    tx_flags_a: assert property ($past(reg_rd) && $past(reg_addr) == `CFM_OFS_TXQ_CTRL
        |-> !(reg_rdata[1] && reg_rdata[2]) && reg_rdata[0] == $past(txen_ff)) else $error("tx flags");
    rx_flags_a: assert property ($past(reg_rd) && $past(reg_addr) == `CFM_OFS_RXQ_CTRL
        |-> $onehot0(reg_rdata[4:2])) else $error("rx level flags clash");
    tx_gate_a: assert property (tx_frame_valid |-> chan_ff[0] && txen_ff)
        else $error("tx offered while inactive");
    tx_irq_a: assert property (tx_queue_irq |-> $past(tx_event.done) && $past(mier_ff[24]))
        else $error("tx irq without cause");
    tx_last_a: assert property (tx_queue_irq && $past(mier_ff[25]) && !$past(reg_wr)
        |-> !tx_frame_valid) else $error("tx irq before queue empty");
    rx_irq_a: assert property (rx_queue_irq
        |-> $past(rx_frame_valid) && $past(mier_ff[28]) && $past(chan_ff[0])) else $error("rx irq without cause");
    head_hold_a: assert property (tx_frame_valid && $past(tx_frame_valid) && !$past(tx_event.done)
        |-> $stable(tx_frame)) else $error("tx head moved without pop");

    // Main scenarios reached
    cover property (tx_queue_irq && $past(mier_ff[25]));
    cover property (rx_queue_irq);
    cover property (tx_event.done && !tx_frame_valid);
endmodule

bind cfm_top cfm_monitor mon (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_frame_valid(tx_frame_valid),
    .tx_frame(tx_frame), .tx_event(tx_event), .rx_frame_valid(rx_frame_valid),
    .tx_queue_irq(tx_queue_irq), .rx_queue_irq(rx_queue_irq));

// ### testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    logic clk, rst_n, reg_wr, reg_rd, go;
    logic [7:0] reg_addr, lag;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic tx_frame_valid, tx_busy, rx_frame_valid, tx_queue_irq, rx_queue_irq;
    cfm_pkg::cfm_msg_s tx_frame, rx_frame;
    cfm_pkg::cfm_txev_s tx_event;
    int errors, cmp_count, cyc, ntx, nrx;
    logic [28:0] sent[$];
    logic [31:0] cfg[3] = '{32'h0100_0000, 32'h0300_0000, 32'h0200_0000};
    int xtx[3] = '{4, 1, 0};
    logic [31:0] rxs[4] = '{32'h1, 32'h1, 32'h9, 32'h5};

    cfm_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_frame_valid(tx_frame_valid),
        .tx_frame(tx_frame), .tx_busy(tx_busy), .tx_event(tx_event), .rx_frame_valid(rx_frame_valid),
        .rx_frame(rx_frame), .tx_queue_irq(tx_queue_irq), .rx_queue_irq(rx_queue_irq));
    cfm_engine_model m (.clk(clk), .go(go), .lag(lag), .tx_frame_valid(tx_frame_valid),
        .tx_busy(tx_busy), .tx_event(tx_event), .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Irq pulses, sent heads and the hang guard
    always @(posedge clk) begin
        cyc++;
        if (tx_queue_irq === 1'b1) ntx++;
        if (rx_queue_irq === 1'b1) nrx++;
        if (tx_event.done === 1'b1) sent.push_back(tx_frame.id);
        if (cyc == 30000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Read, retried up to n times when waiting on the queue
    task automatic ck(input logic [7:0] a, input logic [31:0] e, input int n = 1);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1;
            d = reg_rdata;
            if (d === e) break;
        end
        cmp(d, e);
    endtask

    task automatic push(input logic [28:0] id);
        wr(8'h30, {3'h0, id});
        wr(8'h34, 32'h8);
        wr(8'h10, 32'hff);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        {rst_n, reg_wr, reg_rd, go, reg_addr, reg_wdata} = '0;
        lag = 8'h02;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        // Reset state, unmapped and frozen places
        ck(8'h08, 32'h4);
        ck(8'h0c, 32'h10);
        ck(8'hfc, 32'h0);
        wr(8'h00, 32'h1);
        wr(8'h28, 32'h80);
        ck(8'h28, 32'h0);
        wr(8'h18, 32'h1fff_ff00);
        wr(8'h1c, 32'h1fff_ffff);
        wr(8'h20, 32'h100);
        wr(8'h24, 32'h456);
        wr(8'h08, 32'h1);
        wr(8'h10, 32'hfe);
        ck(8'h08, 32'h5);
        $display("setup done");
        // Fill past full, drain, under three irq settings
        for (int r = 0; r < 3; r++) begin
            go <= 1'b0;
            wr(8'h04, cfg[r]);
            for (int i = 0; i < 5; i++) push(29'(i + 8'h11));
            ck(8'h08, 32'h3);
            ntx = 0;
            sent.delete();
            go <= 1'b1;
            ck(8'h08, 32'h5, 80);
            for (int i = 0; i < 4; i++) cmp({3'h0, sent[i]}, 32'(i + 8'h11));
            cmp(ntx, xtx[r]);
            $display("tx round %0d done", r);
        end
        // Abort in mid-send drops what is left
        go <= 1'b0;
        lag <= 8'h28;
        for (int i = 0; i < 3; i++) push(29'(i + 8'h21));
        sent.delete();
        go <= 1'b1;
        wait (tx_busy === 1'b1);
        wr(8'h08, 32'h0);
        ck(8'h08, 32'h0);
        ck(8'h08, 32'h4, 80);
        cmp(sent.size(), 1);
        wr(8'h08, 32'h1);
        ck(8'h08, 32'h5);
        $display("abort done");
        // Filter, levels, overwrite then overrun
        wr(8'h04, 32'h1000_0000);
        wr(8'h0c, 32'h1);
        m.rx_send(29'h7);
        ck(8'h0c, 32'h11);
        for (int i = 0; i < 4; i++) begin
            m.rx_send(i == 3 ? 29'h456 : 29'(i + 12'h101));
            ck(8'h0c, rxs[i]);
        end
        cmp(nrx, 4);
        ck(8'h40, 32'h101);
        m.rx_send(29'h105);
        ck(8'h0c, 32'h7);
        ck(8'h40, 32'h102);
        wr(8'h00, 32'h3);
        m.rx_send(29'h106);
        ck(8'h40, 32'h102);
        wr(8'h0c, 32'h1);
        ck(8'h0c, 32'h5);
        wr(8'h04, 32'h3000_0000);
        nrx = 0;
        wr(8'h14, 32'hff);
        ck(8'h0c, 32'h9);
        wr(8'h14, 32'hff);
        m.rx_send(29'h107);
        ck(8'h0c, 32'h9);
        cmp(nrx, 1);
        wr(8'h0c, 32'h0);
        m.rx_send(29'h108);
        ck(8'h0c, 32'h8);
        $display("rx done");
        end_of_test();
    end
endmodule
